/* File: sim/psh_host.sv */
`timescale 1ns/10ps
`default_nettype none
module psh_host (
	// clock and reset
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	// driver flags
	input wire logic i_complete,
	input wire logic i_zone,
	// host pins
	output logic o_start_strobe,
	output logic [2:0] o_pos_select,
	output logic [7:0] o_last_cnt
);
	// ----------------------------------------
	// completion bookkeeping
	// ----------------------------------------
	logic done_q;
	// count finished moves that end outside the zone window
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			done_q <= 1'b0;
			o_last_cnt <= 8'h00;
		end else begin
			done_q <= i_complete;
			if (i_complete && !done_q && !i_zone)
				o_last_cnt <= o_last_cnt + 8'h01;
		end
	end
	// ----------------------------------------
	// start handshake
	// ----------------------------------------
	// select settles one cycle before the strobe rises
	task automatic start(input logic [2:0] sel);
		int n;
		n = 0;
		@(posedge i_sys_clk);
		o_pos_select <= sel;
		@(posedge i_sys_clk);
		o_start_strobe <= 1'b1;
		// hold long enough for the synchroniser and until complete is low
		do begin
			@(posedge i_sys_clk);
			n++;
		end while (n < 6 || i_complete !== 1'b0);
		o_start_strobe <= 1'b0;
		repeat (3) @(posedge i_sys_clk);
	endtask : start
	// idle pins at time zero
	initial begin
		o_start_strobe = 1'b0;
		o_pos_select = 3'h0;
	end
endmodule : psh_host
`default_nettype wire

/* File: sim/tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
`include "psh_map.svh"
module tb_top;
	import psh_pkg::*;
	// ----------------------------------------
	// signals
	// ----------------------------------------
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic aw_v, w_v, b_r, ar_v, r_r, pause, cancel, strobe, home, mend;
	logic aw_rdy, w_rdy, b_v, ar_rdy, r_v, cmpl, mov, zone, hdone;
	logic [7:0] aw_a, ar_a, last_cnt;
	logic [2:0] sel;
	logic [3:0] strb;
	logic [1:0] b_resp, r_resp;
	logic [15:0] dacc;
	psh_word_t w_d, r_d, acc1;
	logic [33:0] expq[$];
	int error_cnt = 0;
	int cmp_count = 0;
	int n;
	// 125 MHz clock
	always #4 clk = ~clk;
	psh_top #(.P_CANCEL_CYC(20)) psh_top_i (
		.i_sys_clk(clk), .i_rst_n(rst_n),
		.i_s_awvalid(aw_v), .o_s_awready(aw_rdy), .i_s_awaddr(aw_a),
		.i_s_wvalid(w_v), .o_s_wready(w_rdy), .i_s_wdata(w_d),
		.i_s_wstrb(strb), .o_s_bvalid(b_v), .i_s_bready(b_r),
		.o_s_bresp(b_resp), .i_s_arvalid(ar_v), .o_s_arready(ar_rdy),
		.i_s_araddr(ar_a), .o_s_rvalid(r_v), .i_s_rready(r_r),
		.o_s_rdata(r_d), .o_s_rresp(r_resp), .i_start_strobe(strobe),
		.i_pos_select(sel), .i_pause_request(pause),
		.i_reset_request(cancel), .i_home_request(home),
		.i_mech_end(mend), .o_position_complete_flag(cmpl),
		.o_moving_flag(mov), .o_zone_flag(zone), .o_home_done(hdone)
	);
	psh_host psh_host_i (
		.i_sys_clk(clk), .i_rst_n(rst_n), .i_complete(cmpl),
		.i_zone(zone), .o_start_strobe(strobe), .o_pos_select(sel),
		.o_last_cnt(last_cnt)
	);
	// ----------------------------------------
	// checking and closing
	// ----------------------------------------
	task automatic check(input logic [33:0] seen, input logic [33:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic tally_and_finish;
		$display("errors=%0d compares=%0d", error_cnt, cmp_count);
		if (error_cnt == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : tally_and_finish
	// read results are matched against the oldest note
	always @(posedge clk) begin
		if (r_v === 1'b1 && r_r === 1'b1)
			check({r_resp, r_d}, expq.pop_front());
	end
	// ----------------------------------------
	// bus tasks
	// ----------------------------------------
	task automatic axw(input logic [7:0] a, input psh_word_t d,
			input logic [1:0] er);
		int k;
		k = 0;
		@(posedge clk);
		aw_a <= a;
		w_d <= d;
		aw_v <= 1'b1;
		w_v <= 1'b1;
		b_r <= 1'b1;
		do begin
			@(posedge clk);
			k++;
			if (aw_v && aw_rdy)
				aw_v <= 1'b0;
			if (w_v && w_rdy)
				w_v <= 1'b0;
		end while (b_v !== 1'b1 && k < 500);
		b_r <= 1'b0;
		if (k >= 500) error_cnt++;
		check({32'h0000_0000, b_resp}, {32'h0000_0000, er});
	endtask : axw
	task automatic axr(input logic [7:0] a, input psh_word_t ed,
			input logic [1:0] er);
		int k;
		k = 0;
		expq.push_back({er, ed});
		@(posedge clk);
		ar_a <= a;
		ar_v <= 1'b1;
		r_r <= 1'b1;
		do begin
			@(posedge clk);
			k++;
			if (ar_v && ar_rdy)
				ar_v <= 1'b0;
		end while (r_v !== 1'b1 && k < 500);
		r_r <= 1'b0;
		if (k >= 500) error_cnt++;
	endtask : axr
	// one table entry through the select register
	task automatic prog(input psh_word_t i, input psh_word_t p,
			input psh_word_t at, input psh_word_t ac);
		axw(`PSH_OFS_TSEL, i, `PSH_RESP_OKAY);
		axw(`PSH_OFS_TPOS, p, `PSH_RESP_OKAY);
		axw(`PSH_OFS_TATTR, at, `PSH_RESP_OKAY);
		axw(`PSH_OFS_TACC, ac, `PSH_RESP_OKAY);
	endtask : prog
	// wait for completion, then compare complete, moving, zone
	task automatic wait_done(input logic [2:0] ef);
		int k;
		k = 0;
		while (cmpl !== 1'b1 && k < 5000) begin
			@(posedge clk);
			k++;
		end
		check({31'h0000_0000, cmpl, mov, zone}, {31'h0000_0000, ef});
	endtask : wait_done
	// ----------------------------------------
	// watchdog
	// ----------------------------------------
	initial begin
		#(8 * 60000);
		error_cnt++;
		tally_and_finish;
	end
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		{aw_v, w_v, b_r, ar_v, r_r, pause, cancel, home, mend} = 9'h000;
		strb = 4'hF;
		aw_a = 8'h00;
		ar_a = 8'h00;
		w_d = 32'h0000_0000;
		n = $urandom(23);
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		// reset values and two unmapped places
		axr(`PSH_OFS_WIDTH, `PSH_WIDTH_RST, `PSH_RESP_OKAY);
		axr(`PSH_OFS_SPEED, `PSH_SPEED_RST, `PSH_RESP_OKAY);
		axr(8'h3C, 32'h0000_0000, `PSH_RESP_SLVERR);
		axw(8'h40, 32'h0000_0000, `PSH_RESP_SLVERR);
		axw(`PSH_OFS_WIDTH, 32'h0000_0000, `PSH_RESP_OKAY);
		axw(`PSH_OFS_SPEED, 32'h0000_0001, `PSH_RESP_OKAY);
		axw(`PSH_OFS_ZONE_HI, 32'h0000_012C, `PSH_RESP_OKAY);
		// only the low byte lane may land
		strb <= 4'h1;
		axw(`PSH_OFS_ZONE_HI, 32'hFFFF_FF2D, `PSH_RESP_OKAY);
		strb <= 4'hF;
		axr(`PSH_OFS_ZONE_HI, 32'h0000_012D, `PSH_RESP_OKAY);
		axw(`PSH_OFS_ZONE_LO, 32'h0000_0063, `PSH_RESP_OKAY);
		acc1 = $urandom;
		prog(1, 32'h0000_0064, 0, acc1);
		prog(2, 32'h0000_0032, 1, $urandom);
		prog(3, 32'h0000_012C, 0, $urandom);
		prog(4, 32'hFFFF_FFE2, 1, $urandom);
		// absolute move inside the zone
		psh_host_i.start(3'h1);
		check({32'h0000_0000, cmpl, mov}, 34'h1);
		wait_done(3'b101);
		axr(`PSH_OFS_TARGET, 32'h0000_0064, `PSH_RESP_OKAY);
		axr(`PSH_OFS_CURPOS, 32'h0000_0064, `PSH_RESP_OKAY);
		axr(`PSH_OFS_ACCACT, acc1, `PSH_RESP_OKAY);
		// relative step from the last target
		psh_host_i.start(3'h2);
		wait_done(3'b101);
		axr(`PSH_OFS_TARGET, 32'h0000_0096, `PSH_RESP_OKAY);
		// relative starts stacked on a running move
		psh_host_i.start(3'h3);
		psh_host_i.start(3'h2);
		psh_host_i.start(3'h2);
		axr(`PSH_OFS_TARGET, 32'h0000_0190, `PSH_RESP_OKAY);
		psh_host_i.start(3'h4);
		axr(`PSH_OFS_TARGET, 32'h0000_0172, `PSH_RESP_OKAY);
		wait_done(3'b100);
		axr(`PSH_OFS_CURPOS, 32'h0000_0172, `PSH_RESP_OKAY);
		// direct mode ramp taken on the edge only
		dacc = 16'($urandom);
		axw(`PSH_OFS_CTRL, 32'h0000_0001, `PSH_RESP_OKAY);
		axw(`PSH_OFS_DPOS, 32'h0000_01F4, `PSH_RESP_OKAY);
		axw(`PSH_OFS_DACC, {16'h0000, dacc}, `PSH_RESP_OKAY);
		psh_host_i.start(3'h0);
		axw(`PSH_OFS_DACC, {16'h0000, ~dacc}, `PSH_RESP_OKAY);
		axr(`PSH_OFS_ACCACT, {dacc, dacc}, `PSH_RESP_OKAY);
		wait_done(3'b100);
		axr(`PSH_OFS_CURPOS, 32'h0000_01F4, `PSH_RESP_OKAY);
		// rotary paths and push relative with travel held still
		axw(`PSH_OFS_SPEED, 32'hFFFF_FFFF, `PSH_RESP_OKAY);
		axw(`PSH_OFS_CTRL, 32'h0000_000B, `PSH_RESP_OKAY);
		axw(`PSH_OFS_DPOS, 32'h0000_8C96, `PSH_RESP_OKAY);
		psh_host_i.start(3'h0);
		axr(`PSH_OFS_TARGET, 32'hFFFF_FFF6, `PSH_RESP_OKAY);
		axw(`PSH_OFS_CTRL, 32'h0000_000F, `PSH_RESP_OKAY);
		axw(`PSH_OFS_DPOS, 32'h0000_01E0, `PSH_RESP_OKAY);
		psh_host_i.start(3'h0);
		axr(`PSH_OFS_TARGET, 32'h0000_8E80, `PSH_RESP_OKAY);
		axw(`PSH_OFS_CTRL, 32'h0000_0000, `PSH_RESP_OKAY);
		prog(5, 32'h0000_0064, 2, $urandom);
		prog(6, 32'h0000_000A, 3, $urandom);
		psh_host_i.start(3'h5);
		psh_host_i.start(3'h6);
		axr(`PSH_OFS_TARGET, 32'h0000_01FE, `PSH_RESP_OKAY);
		axw(`PSH_OFS_SPEED, 32'h0000_0001, `PSH_RESP_OKAY);
		wait_done(3'b100);
		// cancel while paused, completion after the counted delay
		axw(`PSH_OFS_CTRL, 32'h0000_0000, `PSH_RESP_OKAY);
		psh_host_i.start(3'h3);
		pause <= 1'b1;
		repeat (8) @(posedge clk);
		cancel <= 1'b1;
		repeat (8) @(posedge clk);
		cancel <= 1'b0;
		pause <= 1'b0;
		n = 0;
		while (cmpl !== 1'b1 && n < 500) begin
			@(posedge clk);
			n++;
		end
		check({33'h0, (n >= 20 && n <= 40)}, 34'h1);
		check({33'h0, mov}, 34'h0);
		// home return: pause after the end push restarts the seek
		home <= 1'b1;
		repeat (20) @(posedge clk);
		mend <= 1'b1;
		repeat (8) @(posedge clk);
		{mend, pause} <= 2'b01;
		repeat (8) @(posedge clk);
		pause <= 1'b0;
		repeat (8) @(posedge clk);
		mend <= 1'b1;
		wait_done(3'b100);
		check({33'h0, hdone}, 34'h1);
		axr(`PSH_OFS_CURPOS, 32'h0000_0000, `PSH_RESP_OKAY);
		check({26'h0, last_cnt}, 34'h5);
		tally_and_finish;
	end
endmodule : tb_top
`default_nettype wire

/* File: verilog/psh_map.svh */
// Contract
// - start strobe clears complete, raises moving
// - direct mode: one 16-bit ramp, taken on edge
// - table entries carry own accel and decel
// - pause: suspend before push, restart after
// - completion sets complete, zone when inside window (cancel and home completions leave zone low)
// - moving drops together with complete rising
// - incremental attribute 1 relative, 0 absolute
// - relative start mid-move: target plus amount
// - each further relative start adds once more
// - push relative: current position plus amount
// - shortcut setting enables shortest rotary path
// - single direction allows endless one-way rotation (code applies it only when the shortcut bit is also set)
// - complete asserts on entering positioning band
// - newest target always overrides running one (starts are ignored while homing)
// - rotary unit: 100 linear units per degree
// - reset while paused cancels, complete after 1 ms
`ifndef PSH_MAP_SVH
`define PSH_MAP_SVH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define PSH_OFS_CTRL 8'h00
`define PSH_OFS_WIDTH 8'h04
`define PSH_OFS_ZONE_HI 8'h08
`define PSH_OFS_ZONE_LO 8'h0C
`define PSH_OFS_SPEED 8'h10
`define PSH_OFS_DPOS 8'h14
`define PSH_OFS_DACC 8'h18
`define PSH_OFS_TSEL 8'h1C
`define PSH_OFS_TPOS 8'h20
`define PSH_OFS_TATTR 8'h24
`define PSH_OFS_TACC 8'h28
`define PSH_OFS_STATUS 8'h2C
`define PSH_OFS_CURPOS 8'h30
`define PSH_OFS_TARGET 8'h34
`define PSH_OFS_ACCACT 8'h38
// ----------------------------------------
// field positions
// ----------------------------------------
`define PSH_CTRL_DIRECT 0
`define PSH_CTRL_SHORT 1
`define PSH_CTRL_SINGLE 2
`define PSH_CTRL_ROTARY 3
`define PSH_CTRL_DINCR 4
`define PSH_ATTR_INCR 0
`define PSH_ATTR_PUSH 1
// ----------------------------------------
// reset values and scales
// ----------------------------------------
`define PSH_WIDTH_RST 32'h0000_000A
`define PSH_SPEED_RST 32'h0000_0004
`define PSH_REV 32'h0000_8CA0
`define PSH_HALF_REV 32'h0000_4650
`define PSH_HOME_OFS 32'h0000_0064
`define PSH_RESP_OKAY 2'h0
`define PSH_RESP_SLVERR 2'h2
// ----------------------------------------
// timing
// ----------------------------------------
`define PSH_CLK_NS 8
`define PSH_CANCEL_NS 1000000
`endif

/* File: verilog/psh_pkg.sv */
package psh_pkg;
	// bus word and signed position
	typedef logic [31:0] psh_word_t;
	typedef logic signed [31:0] psh_pos_t;
	// home return sequence, gray along the usual path
	typedef enum logic [1:0] {
		H_IDLE = 2'h0,
		H_SEEK = 2'h1,
		H_BACK = 2'h3,
		H_DONE = 2'h2
	} psh_home_t;
endpackage : psh_pkg

/* File: verilog/psh_sync.sv */
`timescale 1ns/10ps
`default_nettype none
module psh_sync #(
	parameter int W = 8
) (
	// clock and reset
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	// pins and clean levels
	input wire logic [W-1:0] i_async,
	output logic [W-1:0] o_level
);
	// ----------------------------------------
	// three stages per pin
	// ----------------------------------------
	genvar g;
	generate
		for (g = 0; g < W; g++) begin : g_bit
			logic s1;
			logic s2;
			logic s3;
			// level moves only when stages two and three agree
			always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
				if (!i_rst_n) begin
					s1 <= 1'b0;
					s2 <= 1'b0;
					s3 <= 1'b0;
					o_level[g] <= 1'b0;
				end else begin
					s1 <= i_async[g];
					s2 <= s1;
					s3 <= s2;
					if (s2 == s3) o_level[g] <= s3;
				end
			end
		end
	endgenerate
endmodule : psh_sync
`default_nettype wire

/* File: verilog/psh_top.sv */
// Local design decisions: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "psh_map.svh"
module psh_top #(
	parameter int P_CANCEL_CYC = `PSH_CANCEL_NS / `PSH_CLK_NS
) (
	// clock and reset
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	// axi4-lite write
	input wire logic i_s_awvalid,
	output logic o_s_awready,
	input wire logic [7:0] i_s_awaddr,
	input wire logic i_s_wvalid,
	output logic o_s_wready,
	input wire psh_pkg::psh_word_t i_s_wdata,
	input wire logic [3:0] i_s_wstrb,
	output logic o_s_bvalid,
	input wire logic i_s_bready,
	output logic [1:0] o_s_bresp,
	// axi4-lite read
	input wire logic i_s_arvalid,
	output logic o_s_arready,
	input wire logic [7:0] i_s_araddr,
	output logic o_s_rvalid,
	input wire logic i_s_rready,
	output psh_pkg::psh_word_t o_s_rdata,
	output logic [1:0] o_s_rresp,
	// host pins
	input wire logic i_start_strobe,
	input wire logic [2:0] i_pos_select,
	input wire logic i_pause_request,
	input wire logic i_reset_request,
	input wire logic i_home_request,
	input wire logic i_mech_end,
	// driver flags
	output logic o_position_complete_flag,
	output logic o_moving_flag,
	output logic o_zone_flag,
	output logic o_home_done
);
	import psh_pkg::*;
	// ----------------------------------------
	// pin synchronisers and edges
	// ----------------------------------------
	logic [7:0] pin_raw;
	logic [7:0] pin_lvl;
	logic start_d;
	logic home_d;
	logic start_pulse;
	logic home_pulse;
	logic [2:0] sel;
	logic pause;
	logic rreq;
	logic mend;
	assign pin_raw = {i_mech_end, i_home_request, i_reset_request,
		i_pause_request, i_pos_select, i_start_strobe};
	psh_sync #(.W(8)) u_sync (
		.i_sys_clk(i_sys_clk),
		.i_rst_n(i_rst_n),
		.i_async(pin_raw),
		.o_level(pin_lvl)
	);
	assign sel = pin_lvl[3:1];
	assign pause = pin_lvl[4];
	assign rreq = pin_lvl[5];
	assign mend = pin_lvl[7];
	// rising edges only; strobe may stay high until complete drops
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			start_d <= 1'b0;
			home_d <= 1'b0;
		end else begin
			start_d <= pin_lvl[0];
			home_d <= pin_lvl[6];
		end
	end
	assign start_pulse = pin_lvl[0] & ~start_d;
	assign home_pulse = pin_lvl[6] & ~home_d;
	// ----------------------------------------
	// registers and position table
	// ----------------------------------------
	logic [4:0] ctrl;
	psh_pos_t pos_width, zone_hi, zone_lo, dpos, tgt, pos, pos_mod;
	psh_word_t speed, acc_act, w_data, wm;
	logic [15:0] dacc;
	logic [2:0] tbl_sel;
	psh_pos_t tbl_pos [0:7];
	logic [1:0] tbl_attr [0:7];
	psh_word_t tbl_acc [0:7];
	logic push_trav, homing, cancel_position_complete_flag;
	psh_home_t home_st;
	// current value and decode of one offset
	function automatic psh_word_t reg_val(input logic [7:0] a);
		psh_word_t r;
		r = '0;
		case (a)
			`PSH_OFS_CTRL: r[4:0] = ctrl;
			`PSH_OFS_WIDTH: r = pos_width;
			`PSH_OFS_ZONE_HI: r = zone_hi;
			`PSH_OFS_ZONE_LO: r = zone_lo;
			`PSH_OFS_SPEED: r = speed;
			`PSH_OFS_DPOS: r = dpos;
			`PSH_OFS_DACC: r[15:0] = dacc;
			`PSH_OFS_TSEL: r[2:0] = tbl_sel;
			`PSH_OFS_TPOS: r = tbl_pos[tbl_sel];
			`PSH_OFS_TATTR: r[1:0] = tbl_attr[tbl_sel];
			`PSH_OFS_TACC: r = tbl_acc[tbl_sel];
			`PSH_OFS_STATUS: r[5:0] = {push_trav, homing, pause,
				o_zone_flag, o_moving_flag, o_position_complete_flag};
			`PSH_OFS_CURPOS: r = pos;
			`PSH_OFS_TARGET: r = tgt;
			`PSH_OFS_ACCACT: r = acc_act;
			default: r = '0;
		endcase
		return r;
	endfunction : reg_val
	function automatic logic reg_hit(input logic [7:0] a);
		return (a[1:0] == 2'h0) && (a <= `PSH_OFS_ACCACT);
	endfunction : reg_hit
	// ----------------------------------------
	// axi4-lite slave
	// ----------------------------------------
	logic [7:0] aw_addr;
	logic [3:0] w_strb;
	logic aw_got, w_got, wr_do;
	assign wr_do = aw_got & w_got & ~o_s_bvalid;
	// byte-lane merge of the write into the current value
	always_comb begin
		wm = reg_val(aw_addr);
		for (int b = 0; b < 4; b++) begin
			if (w_strb[b]) wm[8*b +: 8] = w_data[8*b +: 8];
		end
	end
	// address and data taken in either order, response after both
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_s_awready <= 1'b1;
			o_s_wready <= 1'b1;
			o_s_bvalid <= 1'b0;
			o_s_bresp <= `PSH_RESP_OKAY;
			aw_got <= 1'b0;
			w_got <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= '0;
			w_strb <= 4'h0;
		end else begin
			if (i_s_awvalid && o_s_awready) begin
				aw_addr <= i_s_awaddr;
				aw_got <= 1'b1;
				o_s_awready <= 1'b0;
			end
			if (i_s_wvalid && o_s_wready) begin
				w_data <= i_s_wdata;
				w_strb <= i_s_wstrb;
				w_got <= 1'b1;
				o_s_wready <= 1'b0;
			end
			if (wr_do) begin
				aw_got <= 1'b0;
				w_got <= 1'b0;
				o_s_bvalid <= 1'b1;
				o_s_bresp <= reg_hit(aw_addr) ? `PSH_RESP_OKAY :
					`PSH_RESP_SLVERR;
			end else if (o_s_bvalid && i_s_bready) begin
				o_s_bvalid <= 1'b0;
				o_s_awready <= 1'b1;
				o_s_wready <= 1'b1;
			end
		end
	end
	// read answer one cycle after the address is taken
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_s_arready <= 1'b1;
			o_s_rvalid <= 1'b0;
			o_s_rdata <= '0;
			o_s_rresp <= `PSH_RESP_OKAY;
		end else if (i_s_arvalid && o_s_arready) begin
			o_s_arready <= 1'b0;
			o_s_rvalid <= 1'b1;
			o_s_rdata <= reg_val(i_s_araddr);
			o_s_rresp <= reg_hit(i_s_araddr) ? `PSH_RESP_OKAY :
				`PSH_RESP_SLVERR;
		end else if (o_s_rvalid && i_s_rready) begin
			o_s_rvalid <= 1'b0;
			o_s_arready <= 1'b1;
		end
	end
	// register writes; read-only offsets ignore data
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ctrl <= 5'h00;
			pos_width <= `PSH_WIDTH_RST;
			zone_hi <= '0;
			zone_lo <= '0;
			speed <= `PSH_SPEED_RST;
			dpos <= '0;
			dacc <= 16'h0000;
			tbl_sel <= 3'h0;
			for (int i = 0; i < 8; i++) begin
				tbl_pos[i] <= '0;
				tbl_attr[i] <= 2'h0;
				tbl_acc[i] <= '0;
			end
		end else if (wr_do) begin
			case (aw_addr)
				`PSH_OFS_CTRL: ctrl <= wm[4:0];
				`PSH_OFS_WIDTH: pos_width <= wm;
				`PSH_OFS_ZONE_HI: zone_hi <= wm;
				`PSH_OFS_ZONE_LO: zone_lo <= wm;
				`PSH_OFS_SPEED: speed <= wm;
				`PSH_OFS_DPOS: dpos <= wm;
				`PSH_OFS_DACC: dacc <= wm[15:0];
				`PSH_OFS_TSEL: tbl_sel <= wm[2:0];
				`PSH_OFS_TPOS: tbl_pos[tbl_sel] <= wm;
				`PSH_OFS_TATTR: tbl_attr[tbl_sel] <= wm[1:0];
				`PSH_OFS_TACC: tbl_acc[tbl_sel] <= wm;
				default: ;
			endcase
		end
	end
	// ----------------------------------------
	// command resolution
	// ----------------------------------------
	logic direct, rotary, cmd_incr, cmd_push, start_ok, tick;
	psh_pos_t cmd_val, rot_d, next_tgt, diff, absd;
	psh_word_t sel_acc, step_cnt;
	assign direct = ctrl[`PSH_CTRL_DIRECT];
	assign rotary = ctrl[`PSH_CTRL_ROTARY];
	assign sel_acc = tbl_acc[sel];
	assign start_ok = start_pulse & ~homing;
	assign cmd_val = direct ? dpos : tbl_pos[sel];
	assign cmd_incr = direct ? ctrl[`PSH_CTRL_DINCR] :
		tbl_attr[sel][`PSH_ATTR_INCR];
	assign cmd_push = ~direct & tbl_attr[sel][`PSH_ATTR_PUSH];
	// target from entry: relative, push-relative or rotary absolute
	always_comb begin
		rot_d = cmd_val - pos_mod;
		if (ctrl[`PSH_CTRL_SHORT] && ctrl[`PSH_CTRL_SINGLE]) begin
			if (rot_d < 0) rot_d = rot_d + `PSH_REV;
		end else if (ctrl[`PSH_CTRL_SHORT]) begin
			if (rot_d > $signed(`PSH_HALF_REV)) rot_d = rot_d - `PSH_REV;
			else if (rot_d < -$signed(`PSH_HALF_REV)) rot_d = rot_d + `PSH_REV;
		end
		if (cmd_incr && cmd_push && push_trav) next_tgt = pos + cmd_val;
		else if (cmd_incr) next_tgt = tgt + cmd_val;
		else if (rotary) next_tgt = pos + rot_d;
		else next_tgt = cmd_val;
	end
	// step pacing: one unit per speed+1 cycles
	assign tick = step_cnt >= speed;
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) step_cnt <= '0;
		else step_cnt <= tick ? '0 : step_cnt + 32'h0000_0001;
	end
	// ----------------------------------------
	// target, ramp latch and cancel
	// ----------------------------------------
	logic cancel_now, cancel_done;
	psh_word_t cancel_cnt;
	assign cancel_now = pause & rreq & o_moving_flag & ~cancel_position_complete_flag & ~homing;
	assign cancel_done = cancel_position_complete_flag & ~pause &
		(cancel_cnt == 32'(P_CANCEL_CYC - 1));
	// newest start replaces the running target unless homing is in progress
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			tgt <= '0;
			push_trav <= 1'b0;
			acc_act <= '0;
		end else if (start_ok) begin
			tgt <= next_tgt;
			push_trav <= cmd_push;
			acc_act <= direct ? {dacc, dacc} : sel_acc;
		end else if (cancel_now) begin
			tgt <= pos;
		end else if (home_st == H_SEEK && mend) begin
			tgt <= '0;
		end
	end
	// cancel wait runs only once the pause is released
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cancel_position_complete_flag <= 1'b0;
			cancel_cnt <= '0;
		end else if (cancel_now) begin
			cancel_position_complete_flag <= 1'b1;
			cancel_cnt <= '0;
		end else if (start_ok || cancel_done) begin
			cancel_position_complete_flag <= 1'b0;
		end else if (cancel_position_complete_flag && !pause) begin
			cancel_cnt <= cancel_cnt + 32'h0000_0001;
		end
	end
	// ----------------------------------------
	// position and home return
	// ----------------------------------------
	assign homing = (home_st == H_SEEK) || (home_st == H_BACK);
	// pause freezes travel; rotary position wraps per revolution
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			pos <= '0;
			pos_mod <= '0;
		end else if (home_st == H_SEEK) begin
			if (mend) begin
				pos <= -`PSH_HOME_OFS;
				pos_mod <= `PSH_REV - `PSH_HOME_OFS;
			end else if (tick && !pause) begin
				pos <= pos - 1;
				pos_mod <= (pos_mod == 0) ? `PSH_REV - 1 : pos_mod - 1;
			end
		end else if (tick && !pause && pos != tgt) begin
			if (tgt > pos) begin
				pos <= pos + 1;
				pos_mod <= (pos_mod == `PSH_REV - 1) ? '0 : pos_mod + 1;
			end else begin
				pos <= pos - 1;
				pos_mod <= (pos_mod == 0) ? `PSH_REV - 1 : pos_mod - 1;
			end
		end
	end
	// pause before the end push suspends, after it restarts
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			home_st <= H_IDLE;
			o_home_done <= 1'b0;
		end else begin
			case (home_st)
				H_IDLE, H_DONE: begin
					if (home_pulse) begin
						home_st <= H_SEEK;
						o_home_done <= 1'b0;
					end
				end
				H_SEEK: if (mend) home_st <= H_BACK;
				H_BACK: begin
					if (pause) begin
						home_st <= H_SEEK;
					end else if (pos == 0) begin
						home_st <= H_DONE;
						o_home_done <= 1'b1;
					end
				end
				default: home_st <= H_IDLE;
			endcase
		end
	end
	// ----------------------------------------
	// complete, moving and zone flags
	// ----------------------------------------
	logic band, in_zone;
	assign diff = tgt - pos;
	assign absd = diff[31] ? -diff : diff;
	assign band = absd <= pos_width;
	assign in_zone = (pos >= zone_lo) && (pos <= zone_hi);
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_position_complete_flag <= 1'b0;
			o_moving_flag <= 1'b0;
			o_zone_flag <= 1'b0;
		end else if (start_ok || (home_pulse && !homing)) begin
			o_position_complete_flag <= 1'b0;
			o_moving_flag <= 1'b1;
			o_zone_flag <= 1'b0;
		end else if (cancel_done || (home_st == H_BACK && !pause && pos == 0)) begin
			o_position_complete_flag <= 1'b1;
			o_moving_flag <= 1'b0;
		end else if (o_moving_flag && !homing && !cancel_position_complete_flag && band) begin
			o_position_complete_flag <= 1'b1;
			o_moving_flag <= 1'b0;
			o_zone_flag <= in_zone;
		end
	end
	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_rst_n);
	sequence s_start;
		start_ok;
	endsequence
	sequence s_started;
		!o_position_complete_flag && o_moving_flag;
	endsequence
	a_start_flags: assert property (s_start |=> s_started)
		else $error("start did not clear complete and raise moving");
	a_acc_direct: assert property (start_ok && direct |=>
		acc_act == {$past(dacc), $past(dacc)})
		else $error("direct ramp not taken on start edge");
	a_acc_hold: assert property (!start_ok |=> $stable(acc_act))
		else $error("ramp changed without a start edge");
	a_acc_table: assert property (start_ok && !direct |=>
		acc_act == $past(sel_acc))
		else $error("table ramp not taken from entry");
	a_home_suspend: assert property (home_st == H_SEEK && pause && !mend
		|=> $stable(pos))
		else $error("home seek moved while paused");
	a_home_restart: assert property (home_st == H_BACK && pause
		|=> home_st == H_SEEK)
		else $error("pause after push did not restart homing");
	a_zone_latch: assert property (o_moving_flag && !homing && !cancel_position_complete_flag
		&& band && !start_ok && !home_pulse |=> o_zone_flag == $past(in_zone))
		else $error("zone flag wrong at completion");
	a_flags_swap: assert property ($rose(o_position_complete_flag)
		|-> !o_moving_flag)
		else $error("moving still high with complete");
	a_rel_target: assert property (start_ok && cmd_incr
		&& !(cmd_push && push_trav) |=> tgt == $past(tgt) + $past(cmd_val))
		else $error("relative target not added to prior target");
	a_push_rel: assert property (start_ok && cmd_incr && cmd_push
		&& push_trav |=> tgt == $past(pos) + $past(cmd_val))
		else $error("push relative not from current position");
	a_short_path: assert property (start_ok && !cmd_incr && rotary
		&& ctrl[1] && !ctrl[2] |=> (tgt - $past(pos) <= $signed(`PSH_HALF_REV))
		&& (tgt - $past(pos) >= -$signed(`PSH_HALF_REV)))
		else $error("shortcut took the long way");
	a_one_way: assert property (start_ok && !cmd_incr && rotary
		&& ctrl[1] && ctrl[2] |=> tgt >= $past(pos))
		else $error("single direction target behind position");
	a_band_done: assert property (o_moving_flag && !homing && !cancel_position_complete_flag
		&& band && !start_ok && !home_pulse |=> o_position_complete_flag)
		else $error("complete not raised inside band");
	a_cancel_wait: assert property (cancel_position_complete_flag
		|-> !o_position_complete_flag)
		else $error("complete raised while cancel pending");
	a_cancel_done: assert property (cancel_done && !start_ok && !home_pulse
		|=> o_position_complete_flag && !o_moving_flag)
		else $error("cancel completion timing wrong");
	a_edge_once: assert property (start_pulse |=> !start_pulse)
		else $error("start pulse longer than one cycle");
endmodule : psh_top
`default_nettype wire
